// [verilog/vca_pkg.sv]
// package for the valve cycle counting and position adaptation block
// assumes positions are unsigned percent values, 0 to 100
package vca_pkg;
    // apb register byte offsets
    localparam logic [11:0] VCA_CTRL_OFF = 12'h000;
    localparam logic [11:0] VCA_MAXPOS_OFF = 12'h004;
    localparam logic [11:0] VCA_OFFSET_OFF = 12'h008;
    localparam logic [11:0] VCA_TGT_IN_OFF = 12'h00C;
    localparam logic [11:0] VCA_TGT_USED_OFF = 12'h010;
    localparam logic [11:0] VCA_ACT_REAL_OFF = 12'h014;
    localparam logic [11:0] VCA_ACT_ADPT_OFF = 12'h018;
    localparam logic [11:0] VCA_ACT_RPT_OFF = 12'h01C;
    localparam logic [11:0] VCA_STAT_OFF = 12'h020;
    localparam logic [11:0] VCA_CC_OFF = 12'h024;
    localparam logic [11:0] VCA_CC_TOT_OFF = 12'h028;
    localparam logic [11:0] VCA_IC_OFF = 12'h02C;
    localparam logic [11:0] VCA_IC_TOT_OFF = 12'h030;
    localparam logic [11:0] VCA_CLR_OFF = 12'h034;
    // control register fields
    localparam int VCA_CTRL_RST_EN = 0;
    localparam int VCA_CTRL_ADP_EN = 1;
    localparam int VCA_CTRL_RPT_ADP = 2;
    // clear register fields (write one to clear)
    localparam int VCA_CLR_CC = 0;
    localparam int VCA_CLR_IC = 1;
    // position scale
    localparam logic [7:0] VCA_FULL_OPEN = 8'h64;
    localparam logic [8:0] VCA_CYCLE_TRAVEL = 9'h0C8;
    // reset values
    localparam logic [7:0] VCA_MAXPOS_RST = 8'h64;
    localparam logic [7:0] VCA_OFFSET_RST = 8'h00;
    // position state
    typedef enum logic [1:0] {VCA_POS_CLOSED, VCA_POS_MID, VCA_POS_OPEN} vca_pos_t;
endpackage

// [verilog/vca_travel.sv]
// travel accumulator: adds the size of every position step, one pulse per cycle
// assumes the measured position is synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
module vca_travel (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // measured position
    input wire logic [7:0] pos,
    // one full control cycle done
    output logic cycle_done
);
    import vca_pkg::*;
    logic [7:0] last_pos; // position at previous edge
    logic [8:0] acc; // accumulated travel
    logic [7:0] step; // size of this step
    logic [9:0] next_acc; // travel including this step

    // magnitude of movement, both directions count
    always_comb begin
        step = (pos >= last_pos) ? pos - last_pos : last_pos - pos;
        next_acc = {1'b0, acc} + {2'b00, step};
    end

    // remember previous position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_pos <= 8'h00;
        end else begin
            last_pos <= pos;
        end
    end

    // accumulate; keep remainder past 200 percent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 9'h000;
            cycle_done <= 1'b0;
        end else if (next_acc >= {1'b0, VCA_CYCLE_TRAVEL}) begin
            acc <= 9'(next_acc - {1'b0, VCA_CYCLE_TRAVEL});
            cycle_done <= 1'b1;
        end else begin
            acc <= next_acc[8:0];
            cycle_done <= 1'b0;
        end
    end

    a_travel_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        cycle_done |-> $past(next_acc) >= 10'h0C8)
        else $error("cycle pulse without full travel");
endmodule
`default_nettype wire

// [verilog/vca_counter_pair.sv]
// service counter plus lifetime total; only the service one clears
// assumes inc and clr are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module vca_counter_pair #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // events
    input wire logic inc,
    input wire logic clr,
    // counts
    output logic [WIDTH-1:0] service,
    output logic [WIDTH-1:0] total
);
    initial begin
        if (WIDTH < 1 || WIDTH > 32) $error("vca_counter_pair: WIDTH out of range");
    end

    // service counter, clear together with increment loads one so no event is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            service <= '0;
        end else if (inc) begin
            service <= clr ? WIDTH'(1) : service + WIDTH'(1);
        end else if (clr) begin
            service <= '0;
        end
    end

    // lifetime total, no clear input at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total <= '0;
        end else if (inc) begin
            total <= total + WIDTH'(1);
        end
    end

    a_total_noclr: assert property (@(posedge pclk) disable iff (!presetn)
        clr && !inc |=> total == $past(total))
        else $error("lifetime total changed on clear");
endmodule
`default_nettype wire

// [verilog/vca_top.sv]
// valve position bookkeeping: cycle counters, restriction, offset adaptation
// assumes an apb master on pclk and drive position inputs synchronous to pclk
// Function
// - accumulate travel magnitude; cycle equals 200 percent
// - full cycle increments counter, keeps the remainder past 200 percent
// - service counters clear on request independently
// - lifetime control total never clears
// - lifetime isolation total never clears
// - isolation counts on not-isolated to isolated
// - isolation counting only in isolation variants
// - restriction caps motion at maximum position
// - limit every target; flag restriction active
// - adaptation mode is offset only
// - driven target equals received plus offset
// - adapted actual equals real minus offset
// - reporting mode selects real or adapted
// - report position state and isolation state
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module vca_top #(
    parameter bit HAS_ISOLATION = 1'b1, // variant provides isolation function
    parameter int CNT_WIDTH = 32 // counter width
) (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // targets from pressure controller
    input wire logic pc_target_valid,
    input wire logic [7:0] pc_target,
    // valve drive
    input wire logic [7:0] real_pos,
    input wire logic isolated,
    output logic [7:0] target_used,
    output logic [7:0] actual_pos,
    output logic [1:0] pos_state,
    output logic restrict_active
);
    import vca_pkg::*;

    initial begin
        if (CNT_WIDTH < 1 || CNT_WIDTH > 32) $error("vca_top: CNT_WIDTH out of range");
    end

    // configuration registers
    logic rst_en; // restriction enable
    logic adp_en; // adaptation enable
    logic rpt_adp; // report adapted position
    logic [7:0] max_pos; // restriction maximum
    logic [7:0] offset; // adaptation offset
    logic [7:0] target_in; // nominal target from host or controller
    // bus decode
    logic wr_en; // write access phase
    logic rd_en; // read access phase
    logic addr_ok; // mapped address
    logic clr_cc; // clear control service counter
    logic clr_ic; // clear isolation service counter
    // datapath
    logic [8:0] sum_target; // target plus offset
    logic [7:0] sat_target; // saturated to full open
    logic [7:0] next_target; // restricted target
    logic next_restrict; // limiting applies
    logic [7:0] adapted_pos; // real minus offset
    // counters
    logic cycle_done; // travel completed one cycle
    logic iso_last; // isolation state last edge
    logic iso_inc; // seal compression event
    logic [CNT_WIDTH-1:0] cc_svc;
    logic [CNT_WIDTH-1:0] cc_tot;
    logic [CNT_WIDTH-1:0] ic_svc;
    logic [CNT_WIDTH-1:0] ic_tot;

    // one-word mapped check, used by read and write sides
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= VCA_CLR_OFF);
    endfunction

    // apb answers in the first access cycle
    always_comb begin
        pready = 1'b1;
        addr_ok = is_mapped(paddr);
        wr_en = psel && penable && pwrite;
        rd_en = psel && penable && !pwrite;
        pslverr = psel && penable && !addr_ok;
        clr_cc = wr_en && (paddr == VCA_CLR_OFF) && pstrb[0] && pwdata[VCA_CLR_CC];
        clr_ic = wr_en && (paddr == VCA_CLR_OFF) && pstrb[0] && pwdata[VCA_CLR_IC];
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_en <= 1'b0;
            adp_en <= 1'b0;
            rpt_adp <= 1'b0;
        end else if (wr_en && paddr == VCA_CTRL_OFF && pstrb[0]) begin
            rst_en <= pwdata[VCA_CTRL_RST_EN];
            adp_en <= pwdata[VCA_CTRL_ADP_EN];
            rpt_adp <= pwdata[VCA_CTRL_RPT_ADP];
        end
    end

    // maximum position and offset, clamped to full open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_pos <= VCA_MAXPOS_RST;
            offset <= VCA_OFFSET_RST;
        end else if (wr_en && pstrb[0]) begin
            if (paddr == VCA_MAXPOS_OFF) begin
                max_pos <= (pwdata[7:0] > VCA_FULL_OPEN) ? VCA_FULL_OPEN : pwdata[7:0];
            end
            if (paddr == VCA_OFFSET_OFF) begin
                offset <= (pwdata[7:0] > VCA_FULL_OPEN) ? VCA_FULL_OPEN : pwdata[7:0];
            end
        end
    end

    // nominal target: last write wins, bus over controller in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_in <= 8'h00;
        end else if (wr_en && paddr == VCA_TGT_IN_OFF && pstrb[0]) begin
            target_in <= pwdata[7:0];
        end else if (pc_target_valid) begin
            target_in <= pc_target;
        end
    end

    // offset, saturation, then restriction
    always_comb begin
        sum_target = {1'b0, target_in} + {1'b0, (adp_en ? offset : 8'h00)};
        sat_target = (sum_target > {1'b0, VCA_FULL_OPEN}) ? VCA_FULL_OPEN : sum_target[7:0];
        next_restrict = rst_en && (sat_target > max_pos);
        next_target = next_restrict ? max_pos : sat_target;
        adapted_pos = (real_pos > offset) ? real_pos - offset : 8'h00;
    end

    // registered drive outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_used <= 8'h00;
            restrict_active <= 1'b0;
            actual_pos <= 8'h00;
        end else begin
            target_used <= next_target;
            restrict_active <= next_restrict;
            actual_pos <= (adp_en && rpt_adp) ? adapted_pos : real_pos;
        end
    end

    // position state from measured position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_state <= VCA_POS_CLOSED;
        end else if (real_pos == 8'h00) begin
            pos_state <= VCA_POS_CLOSED;
        end else if (real_pos >= VCA_FULL_OPEN) begin
            pos_state <= VCA_POS_OPEN;
        end else begin
            pos_state <= VCA_POS_MID;
        end
    end

    // isolation edge detect, only in isolation variants
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            iso_last <= 1'b0;
        end else begin
            iso_last <= isolated;
        end
    end
    assign iso_inc = HAS_ISOLATION && isolated && !iso_last;

    // control cycle travel accumulation
    vca_travel u_travel (
        .pclk(pclk),
        .presetn(presetn),
        .pos(real_pos),
        .cycle_done(cycle_done)
    );

    // control cycle counters
    vca_counter_pair #(.WIDTH(CNT_WIDTH)) u_cc (
        .pclk(pclk),
        .presetn(presetn),
        .inc(cycle_done),
        .clr(clr_cc),
        .service(cc_svc),
        .total(cc_tot)
    );

    // isolation cycle counters
    vca_counter_pair #(.WIDTH(CNT_WIDTH)) u_ic (
        .pclk(pclk),
        .presetn(presetn),
        .inc(iso_inc),
        .clr(clr_ic),
        .service(ic_svc),
        .total(ic_tot)
    );

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en && addr_ok) begin
            unique case (paddr)
                VCA_CTRL_OFF: prdata = {29'h0, rpt_adp, adp_en, rst_en};
                VCA_MAXPOS_OFF: prdata = {24'h00_0000, max_pos};
                VCA_OFFSET_OFF: prdata = {24'h00_0000, offset};
                VCA_TGT_IN_OFF: prdata = {24'h00_0000, target_in};
                VCA_TGT_USED_OFF: prdata = {24'h00_0000, target_used};
                VCA_ACT_REAL_OFF: prdata = {24'h00_0000, real_pos};
                VCA_ACT_ADPT_OFF: prdata = {24'h00_0000, adapted_pos};
                VCA_ACT_RPT_OFF: prdata = {24'h00_0000, actual_pos};
                VCA_STAT_OFF: prdata = {28'h000_0000, restrict_active, isolated, pos_state};
                VCA_CC_OFF: prdata = 32'(cc_svc);
                VCA_CC_TOT_OFF: prdata = 32'(cc_tot);
                VCA_IC_OFF: prdata = 32'(ic_svc);
                VCA_IC_TOT_OFF: prdata = 32'(ic_tot);
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    a_restrict_cap: assert property (@(posedge pclk) disable iff (!presetn)
        $past(rst_en) |-> target_used <= $past(max_pos))
        else $error("target above maximum while restricted");
    a_full_open: assert property (@(posedge pclk) disable iff (!presetn)
        target_used <= 8'h64)
        else $error("target beyond full open");
    a_offset_add: assert property (@(posedge pclk) disable iff (!presetn)
        $past(adp_en) && !$past(rst_en) && ($past(target_in) + $past(offset) <= 100)
        |-> target_used == $past(target_in) + $past(offset))
        else $error("target used not input plus offset");
    a_report_adpt: assert property (@(posedge pclk) disable iff (!presetn)
        $past(adp_en) && $past(rpt_adp) && $past(real_pos) >= $past(offset)
        |-> actual_pos == $past(real_pos) - $past(offset))
        else $error("adapted position wrong");
    a_report_real: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(rpt_adp) |-> actual_pos == $past(real_pos))
        else $error("real position not reported");
    a_iso_count: assert property (@(posedge pclk) disable iff (!presetn)
        HAS_ISOLATION && $rose(isolated) |=> ic_tot == $past(ic_tot) + 1'b1)
        else $error("isolation total missed seal event");
    a_iso_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !iso_inc |=> ic_tot == $past(ic_tot))
        else $error("isolation total moved without event");
    a_cc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clr_cc && !cycle_done |=> cc_svc == 0 && cc_tot == $past(cc_tot))
        else $error("control service clear wrong");
    a_cc_count: assert property (@(posedge pclk) disable iff (!presetn)
        cycle_done |=> cc_tot == $past(cc_tot) + 1'b1)
        else $error("control total missed cycle");
endmodule
`default_nettype wire

// [dv/vca_host.sv]
// host model: hands nominal target positions to the block as one-cycle pulses
// assumes pc_target is sampled by the block on the rising edge of pclk
`timescale 1ns/10ps
`default_nettype none
module vca_host (
    // clock
    input wire logic pclk,
    // target to the block
    output logic pc_target_valid,
    output logic [7:0] pc_target
);
    // idle until the bench asks for a transfer
    initial begin
        pc_target_valid = 1'b0;
        pc_target = 8'h00;
    end

    // send the unadapted target; afterwards the bus shows the inverse, not stale data
    task automatic send(input logic [7:0] v);
        @(posedge pclk);
        pc_target_valid <= 1'b1;
        pc_target <= v;
        @(posedge pclk);
        pc_target_valid <= 1'b0;
        pc_target <= ~v;
    endtask
endmodule
`default_nettype wire

// [dv/vca_top_tb.sv]
// self-checking bench: apb master, valve drive stimulus, host model
// assumes vca_top with isolation function and zero-wait apb slave
`timescale 1ns/10ps
`default_nettype none
module vca_top_tb;
    import vca_pkg::*;
    logic pclk = 1'b0; // 40 mhz clock
    logic presetn = 1'b0; // active low reset
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pc_target_valid;
    logic [7:0] pc_target;
    logic [7:0] real_pos = 8'h00; // drive side position
    logic isolated = 1'b0;
    logic [7:0] target_used;
    logic [7:0] actual_pos;
    logic [1:0] pos_state;
    logic restrict_active;
    int err_total = 0;
    int comparisons = 0;
    int seed = 32'h1297;
    logic [31:0] q;
    logic e;
    int t;
    int off;
    int mx;

    vca_top u_vca_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pc_target_valid(pc_target_valid),
        .pc_target(pc_target), .real_pos(real_pos), .isolated(isolated),
        .target_used(target_used), .actual_pos(actual_pos), .pos_state(pos_state),
        .restrict_active(restrict_active));
    vca_host u_vca_host (.pclk(pclk), .pc_target_valid(pc_target_valid),
        .pc_target(pc_target));

    // clock
    always #12.5 pclk = ~pclk;

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    // let registered outputs follow their inputs
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    // move the valve in steps of ten percent, one step per clock
    task automatic mv(input int to);
        while (int'(real_pos) != to) begin
            @(posedge pclk);
            real_pos <= (int'(real_pos) < to) ? real_pos + 8'h0a : real_pos - 8'h0a;
            #1;
        end
        settle();
    endtask

    // expected driven target: offset, saturate, then cap
    function automatic int exp_tgt(int ti, int of, bit adp, bit rs, int m);
        int v;
        v = adp ? ti + of : ti;
        if (v > 100) v = 100;
        if (rs && v > m) v = m;
        return v;
    endfunction

    task automatic end_sim();
        $display("counts: comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(VCA_MAXPOS_OFF, 32'h0000_0064);
        rdc(VCA_CC_TOT_OFF, 32'h0000_0000);
        rdc(12'h040, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        $display("test reset and map done");
        // offset adaptation and reporting modes
        wr(VCA_OFFSET_OFF, 32'h0000_0005);
        wr(VCA_TGT_IN_OFF, 32'h0000_003c);
        wr(VCA_CTRL_OFF, 32'h0000_0006);
        settle();
        chk({24'h0, target_used}, 32'h0000_0041);
        mv(70);
        chk({24'h0, actual_pos}, 32'h0000_0041);
        rdc(VCA_ACT_ADPT_OFF, 32'h0000_0041);
        rdc(VCA_ACT_REAL_OFF, 32'h0000_0046);
        wr(VCA_CTRL_OFF, 32'h0000_0002);
        settle();
        chk({24'h0, actual_pos}, 32'h0000_0046);
        $display("test adaptation done");
        // restriction with random targets from the host
        mx = 50;
        wr(VCA_MAXPOS_OFF, mx);
        for (int i = 0; i < 10; i++) begin
            t = $unsigned($random(seed)) % 101;
            off = (i == 0) ? 100 : $unsigned($random(seed)) % 31;
            wr(VCA_OFFSET_OFF, off);
            wr(VCA_CTRL_OFF, {29'h0, 1'b0, 1'b1, i[0]});
            u_vca_host.send(t[7:0]);
            settle();
            chk(target_used, exp_tgt(t, off, 1'b1, i[0], mx));
            chk(restrict_active, i[0] && (exp_tgt(t, off, 1'b1, 1'b0, mx) > mx));
        end
        wr(VCA_CTRL_OFF, 32'h0000_0000);
        $display("test restriction done");
        // travel: 70 so far, down to 0 and up to 100 reaches 240 -> one cycle, 40 kept
        mv(0);
        chk({30'h0, pos_state}, 32'h0000_0000);
        mv(100);
        chk({30'h0, pos_state}, 32'h0000_0002);
        rdc(VCA_CC_OFF, 32'h0000_0001);
        mv(40);
        rdc(VCA_CC_OFF, 32'h0000_0001);
        chk({30'h0, pos_state}, 32'h0000_0001);
        // 40 kept + 60 + 60 = 160, still short of a full cycle
        mv(100);
        rdc(VCA_CC_OFF, 32'h0000_0001);
        // another 40 of travel reaches exactly 200
        mv(60);
        rdc(VCA_CC_OFF, 32'h0000_0002);
        $display("test travel done");
        // isolation transitions; a held level counts once
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            isolated <= 1'b1;
            repeat (4) @(posedge pclk);
            isolated <= 1'b0;
            settle();
        end
        rdc(VCA_IC_OFF, 32'h0000_0003);
        rdc(VCA_IC_TOT_OFF, 32'h0000_0003);
        // clears touch service counters only
        wr(VCA_CLR_OFF, 32'h0000_0002);
        rdc(VCA_IC_OFF, 32'h0000_0000);
        rdc(VCA_CC_OFF, 32'h0000_0002);
        wr(VCA_CLR_OFF, 32'h0000_0001);
        wr(VCA_CC_TOT_OFF, 32'h0000_0000);
        rdc(VCA_CC_OFF, 32'h0000_0000);
        rdc(VCA_CC_TOT_OFF, 32'h0000_0002);
        rdc(VCA_IC_TOT_OFF, 32'h0000_0003);
        $display("test counters done");
        end_sim();
    end
endmodule
`default_nettype wire
